// file: verilog/cctu_unit.sv
// camera counter timer unit top
`timescale 1ns/1ps
`default_nettype none
`include "cctu_map.svh"
module cctu_unit
	import cctu_pkg::*;
#(
	parameter int W = `CCTU_CNT_W
) (
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       srst,
	// pins
	input  wire logic [`CCTU_ISO_IN_N-1:0]  isoIn,
	input  wire logic [`CCTU_DIFF_N-1:0]    diffIn,
	input  wire logic                       lineIn,
	input  wire logic                       frameIn,
	input  wire logic                       acqActive,
	// trigger control
	input  wire logic [2:0]                 trigSel,
	input  wire logic                       trigEdge,
	input  wire logic                       trigInvert,
	// astable
	input  wire logic                       astEnable,
	input  wire logic [W-1:0]               astPeriod,
	// monostables
	input  wire logic [1:0]                 monoSrc,
	input  wire logic [W-1:0]               exposeWidth,
	input  wire logic [W-1:0]               resetWidth,
	// trigger delay
	input  wire logic                       dlyLines,
	input  wire logic [W-1:0]               dlyCount,
	// event counter
	input  wire cctu_event_t                evSel,
	input  wire cctu_gate_t                 gateSel,
	// isolated outputs
	input  wire cctu_osel_t [`CCTU_ISO_OUT_N-1:0] outSel,
	input  wire logic [`CCTU_ISO_OUT_N-1:0] outSoft,
	// results
	output var  logic                       exposure_sync_out,
	output var  logic                       pixel_reset_out,
	output var  logic                       astableOut,
	output var  logic                       acqTrigger,
	output var  logic                       dlyPending,
	output var  logic [W-1:0]               evRunning,
	output var  logic [W-1:0]               evFinal,
	output var  logic [`CCTU_ISO_OUT_N-1:0] isoOut,
	output var  logic [`CCTU_DIFF_N-1:0]    diffStatus
);
	localparam int PRE_W = 8;
	localparam int IN_N = `CCTU_ISO_IN_N + `CCTU_DIFF_N + 2;
	cctu_tick_if tk();
	assign tk.srst = srst;

	// pin synchronisers, two flops before use
	logic [IN_N-1:0] s1_q, s2_q, s3_q;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= {frameIn, lineIn, diffIn, isoIn};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	wire logic lineRise  = s2_q[IN_N-2] & ~s3_q[IN_N-2];
	wire logic lineFall  = ~s2_q[IN_N-2] & s3_q[IN_N-2];
	wire logic frameRise = s2_q[IN_N-1] & ~s3_q[IN_N-1];
	wire logic frameFall = ~s2_q[IN_N-1] & s3_q[IN_N-1];

	logic [PRE_W-1:0] pre_q, pre_d;
	logic             tick_q, tick_d;
	always_comb begin
		tick_d = 1'b0;
		pre_d  = pre_q + PRE_W'(1);
		if (pre_q == PRE_W'(`CCTU_TICK_CYCLES - 1)) begin
			pre_d  = '0;
			tick_d = 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q  <= pre_d;
			tick_q <= tick_d;
		end
	end
	assign tk.tick = tick_q;

	logic selLvl, selLvlPrev_q, trigHit;
	always_comb begin
		selLvl = 1'b0;
		if (trigSel < 3'(`CCTU_ISO_IN_N + `CCTU_DIFF_N))
			selLvl = s2_q[trigSel] ^ trigInvert;
		trigHit = trigEdge ? (selLvl & ~selLvlPrev_q) : selLvl;
	end
	always_ff @(posedge sys_clk) begin
		if (srst)
			selLvlPrev_q <= 1'b0;
		else
			selLvlPrev_q <= selLvl;
	end

	logic [W-1:0] astCnt_q, astCnt_d;
	logic         astOut_q, astOut_d;
	always_comb begin
		astCnt_d = astCnt_q;
		astOut_d = 1'b0;
		if (!astEnable || astPeriod == W'(`CCTU_ZERO)) begin
			astCnt_d = W'(`CCTU_ZERO);
		end else if (tick_q) begin
			astCnt_d = astCnt_q + W'(`CCTU_ONE);
			if (astCnt_q + W'(`CCTU_ONE) >= astPeriod) begin
				astCnt_d = W'(`CCTU_ZERO);
				astOut_d = 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			astCnt_q <= W'(`CCTU_ZERO);
			astOut_q <= 1'b0;
		end else begin
			astCnt_q <= astCnt_d;
			astOut_q <= astOut_d;
		end
	end

	cctu_dstate_t dSt_q, dSt_d;
	logic [W-1:0] dCnt_q, dCnt_d;
	logic         acqTrig_q, acqTrig_d;
	always_comb begin
		dSt_d     = dSt_q;
		dCnt_d    = dCnt_q;
		acqTrig_d = 1'b0;
		case (dSt_q)
			CCTU_DS_IDLE: begin
				if (trigHit) begin
					if (dlyCount == W'(`CCTU_ZERO)) begin
						acqTrig_d = 1'b1;
					end else begin
						dCnt_d = dlyCount;
						dSt_d  = CCTU_DS_WAIT;
					end
				end
			end
			CCTU_DS_WAIT: begin
				// new hits ignored here
				if (dlyLines ? lineRise : tick_q) begin
					dCnt_d = dCnt_q - W'(`CCTU_ONE);
					if (dCnt_q == W'(`CCTU_ONE)) begin
						acqTrig_d = 1'b1;
						dSt_d     = CCTU_DS_IDLE;
					end
				end
			end
			default: dSt_d = CCTU_DS_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dSt_q     <= CCTU_DS_IDLE;
			dCnt_q    <= W'(`CCTU_ZERO);
			acqTrig_q <= 1'b0;
		end else begin
			dSt_q     <= dSt_d;
			dCnt_q    <= dCnt_d;
			acqTrig_q <= acqTrig_d;
		end
	end
	dly_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
		(dSt_q == CCTU_DS_WAIT && !(dlyLines ? lineRise : tick_q)) |=> (dCnt_q == $past(dCnt_q)))
		else $error("trigger delay restarted while pending");
	dly_nodrop_a: assert property (@(posedge sys_clk) disable iff (srst)
		(dSt_q == CCTU_DS_WAIT && dCnt_q > W'(`CCTU_ONE)) |=> (dSt_q == CCTU_DS_WAIT && !acqTrig_q))
		else $error("trigger delay ended early");
	ast_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
		astOut_q |=> !astOut_q)
		else $error("astable pulse wider than one cycle");

	logic monoFire;
	always_comb begin
		case (monoSrc)
			2'h0:    monoFire = acqTrig_q;
			2'h1:    monoFire = astOut_q;
			2'h2:    monoFire = trigHit;
			default: monoFire = lineRise;
		endcase
	end
	logic expPulse, pixPulse;
	cctu_monostable #(.W(W)) u_expose (.sys_clk(sys_clk), .tk(tk), .fire(monoFire), .width(exposeWidth),
		.pulse(expPulse));
	cctu_monostable #(.W(W)) u_pixrst (.sys_clk(sys_clk), .tk(tk), .fire(monoFire), .width(resetWidth),
		.pulse(pixPulse));

	logic [W-1:0] evRun_q, evRun_d, evFin_q, evFin_d;
	logic         gateOn_q, gateOn_d, evHit, gStart, gEnd;
	always_comb begin
		case (evSel)
			CCTU_EV_LINE:  evHit = lineRise;
			CCTU_EV_FRAME: evHit = frameRise;
			CCTU_EV_USEC:  evHit = tick_q;
			default:       evHit = 1'b0;
		endcase
		case (gateSel)
			CCTU_GT_LINE: begin
				gStart = lineRise;
				gEnd   = lineFall;
			end
			CCTU_GT_FRAME: begin
				gStart = frameRise;
				gEnd   = frameFall;
			end
			CCTU_GT_TRIG: begin
				gStart = selLvl & ~selLvlPrev_q;
				gEnd   = ~selLvl & selLvlPrev_q;
			end
			default: begin
				gStart = acqActive & ~gateOn_q;
				gEnd   = ~acqActive & gateOn_q;
			end
		endcase
		gateOn_d = gateOn_q;
		evRun_d  = evRun_q;
		evFin_d  = evFin_q;
		if (gStart) begin
			gateOn_d = 1'b1;
			evRun_d  = W'(`CCTU_ZERO);
		end else if (gEnd && gateOn_q) begin
			gateOn_d = 1'b0;
			evFin_d  = evRun_q + (evHit ? W'(`CCTU_ONE) : W'(`CCTU_ZERO));
		end else if (gateOn_q && evHit) begin
			evRun_d = evRun_q + W'(`CCTU_ONE);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gateOn_q <= 1'b0;
			evRun_q  <= W'(`CCTU_ZERO);
			evFin_q  <= W'(`CCTU_ZERO);
		end else begin
			gateOn_q <= gateOn_d;
			evRun_q  <= evRun_d;
			evFin_q  <= evFin_d;
		end
	end
	ev_final_a: assert property (@(posedge sys_clk) disable iff (srst)
		(gEnd && gateOn_q && !gStart && !evHit) |=> (evFin_q == $past(evRun_q)))
		else $error("final count not captured");

	logic [`CCTU_ISO_OUT_N-1:0] iso_d, iso_q;
	always_comb begin
		for (int i = 0; i < `CCTU_ISO_OUT_N; i++) begin
			case (outSel[i])
				CCTU_OS_SOFT:    iso_d[i] = outSoft[i];
				CCTU_OS_ASTABLE: iso_d[i] = astOut_q;
				CCTU_OS_EXPOSE:  iso_d[i] = expPulse;
				default:         iso_d[i] = acqTrig_q;
			endcase
		end
	end
	logic expo_q, pix_q;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			iso_q  <= '0;
			expo_q <= 1'b0;
			pix_q  <= 1'b0;
		end else begin
			iso_q  <= iso_d;
			expo_q <= expPulse;
			pix_q  <= pixPulse;
		end
	end
	tick_single_a: assert property (@(posedge sys_clk) disable iff (srst)
		tick_q |=> !tick_q)
		else $error("tick wider than one cycle");

	assign exposure_sync_out = expo_q;
	assign pixel_reset_out   = pix_q;
	assign astableOut        = astOut_q;
	assign acqTrigger        = acqTrig_q;
	assign dlyPending        = dSt_q[1];
	assign evRunning         = evRun_q;
	assign evFinal           = evFin_q;
	assign isoOut            = iso_q;
	assign diffStatus        = s2_q[`CCTU_ISO_IN_N +: `CCTU_DIFF_N];
endmodule : cctu_unit
`default_nettype wire

// file: include/cctu_map.svh
// constants for the camera counter timer unit
`ifndef CCTU_MAP_SVH
`define CCTU_MAP_SVH
`define CCTU_CLK_HZ        10_000_000
`define CCTU_TICK_US       1
`define CCTU_TICK_CYCLES   ((`CCTU_CLK_HZ / 1_000_000) * `CCTU_TICK_US)
`define CCTU_MAX_MINUTES   70
`define CCTU_MAX_PERIOD_US (`CCTU_MAX_MINUTES * 60 * 1_000_000)
`define CCTU_CNT_W         32
`define CCTU_ZERO          32'h0000_0000
`define CCTU_ONE           32'h0000_0001
`define CCTU_ISO_IN_N      2
`define CCTU_ISO_OUT_N     2
`define CCTU_DIFF_N        4
`endif

// file: include/cctu_pkg.sv
// types for the camera counter timer unit
package cctu_pkg;
	typedef enum logic [1:0] {CCTU_EV_LINE = 2'h0, CCTU_EV_FRAME = 2'h1, CCTU_EV_USEC = 2'h2} cctu_event_t;
	typedef enum logic [1:0] {CCTU_GT_LINE = 2'h0, CCTU_GT_FRAME = 2'h1, CCTU_GT_TRIG = 2'h2,
		CCTU_GT_ACQ = 2'h3} cctu_gate_t;
	typedef enum logic [1:0] {CCTU_OS_SOFT = 2'h0, CCTU_OS_ASTABLE = 2'h1, CCTU_OS_EXPOSE = 2'h2,
		CCTU_OS_TRIG = 2'h3} cctu_osel_t;
	typedef enum logic [1:0] {CCTU_DS_IDLE = 2'b01, CCTU_DS_WAIT = 2'b10} cctu_dstate_t;
endpackage : cctu_pkg

// file: include/cctu_tick_if.sv
// shared tick and reset carrier between unit modules
`timescale 1ns/1ps
`default_nettype none
interface cctu_tick_if;
	logic tick;
	logic srst;
	modport src (output tick, input srst);
	modport snk (input tick, input srst);
endinterface : cctu_tick_if
`default_nettype wire

// file: verilog/cctu_monostable.sv
// one monostable pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "cctu_map.svh"
module cctu_monostable #(
	parameter int W = `CCTU_CNT_W
) (
	// clock and tick
	input  wire logic         sys_clk,
	cctu_tick_if.snk          tk,
	// control
	input  wire logic         fire,
	input  wire logic [W-1:0] width,
	// pulse
	output var  logic         pulse
);
	logic [W-1:0] cnt_q, cnt_d;
	logic         on_q, on_d;
	always_comb begin
		cnt_d = cnt_q;
		on_d  = on_q;
		if (fire && !on_q && width != W'(`CCTU_ZERO)) begin
			on_d  = 1'b1;
			cnt_d = width;
		end else if (on_q && tk.tick) begin
			cnt_d = cnt_q - W'(`CCTU_ONE);
			if (cnt_q == W'(`CCTU_ONE))
				on_d = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (tk.srst) begin
			cnt_q <= W'(`CCTU_ZERO);
			on_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			on_q  <= on_d;
		end
	end
	assign pulse = on_q;
	mono_start_a: assert property (@(posedge sys_clk) disable iff (tk.srst)
		(fire && !on_q && width != W'(`CCTU_ZERO)) |=> on_q)
		else $error("monostable did not start");
endmodule : cctu_monostable
`default_nettype wire

// file: verif/cctu_far_model.sv
// camera exposure inputs and trigger sensor pins facing the unit
`timescale 1ns/1ps
`default_nettype none
module cctu_far_model (
	// clock
	input  wire logic        sys_clk,
	// camera exposure inputs
	input  wire logic        exposure_sync_out,
	input  wire logic        pixel_reset_out,
	// sensor pins
	output var  logic [1:0]  isoIn,
	output var  logic [3:0]  diffIn,
	output var  logic        lineIn,
	output var  logic        frameIn,
	// last pulse lengths in cycles
	output var  logic [15:0] expLen,
	output var  logic [15:0] rstLen
);
	logic [15:0] expRun;
	logic [15:0] rstRun;
	initial begin
		{isoIn, diffIn, lineIn, frameIn} = 8'h00;
		{expRun, rstRun, expLen, rstLen} = 64'h0;
	end
	always @(posedge sys_clk) begin
		expRun <= exposure_sync_out ? expRun + 16'h1 : 16'h0;
		rstRun <= pixel_reset_out ? rstRun + 16'h1 : 16'h0;
		if (!exposure_sync_out && expRun != 16'h0) expLen <= expRun;
		if (!pixel_reset_out && rstRun != 16'h0) rstLen <= rstRun;
	end
	// pins are asynchronous: a level set here is only seen after the synchronisers
	task automatic sense(input int sel, input logic v);
		if (sel < 2) isoIn[sel] = v;
		else if (sel < 6) diffIn[sel-2] = v;
		else if (sel == 6) lineIn = v;
		else frameIn = v;
	endtask : sense
endmodule : cctu_far_model
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the camera counter timer unit
`timescale 1ns/1ps
`default_nettype none
module tb
	import cctu_pkg::*;
;
	logic              sys_clk, srst, acqActive, trigEdge, trigInvert, astEnable, dlyLines;
	logic              lineIn, frameIn, exposure_sync_out, pixel_reset_out, astableOut, acqTrigger, dlyPending;
	logic [2:0]        trigSel;
	logic [1:0]        monoSrc, outSoft, isoIn, isoOut;
	logic [3:0]        diffIn, diffStatus;
	logic [15:0]       expLen, rstLen;
	logic [31:0]       astPeriod, exposeWidth, resetWidth, dlyCount, evRunning, evFinal;
	logic [31:0]       astGap, astRun, trigCnt, n0;
	cctu_event_t       evSel;
	cctu_gate_t        gateSel;
	cctu_osel_t  [1:0] outSel;
	int                miscompares, compares, n;
	cctu_unit dut (.sys_clk(sys_clk), .srst(srst), .isoIn(isoIn), .diffIn(diffIn), .lineIn(lineIn),
		.frameIn(frameIn), .acqActive(acqActive), .trigSel(trigSel), .trigEdge(trigEdge), .trigInvert(trigInvert),
		.astEnable(astEnable), .astPeriod(astPeriod), .monoSrc(monoSrc), .exposeWidth(exposeWidth),
		.resetWidth(resetWidth), .dlyLines(dlyLines), .dlyCount(dlyCount), .evSel(evSel), .gateSel(gateSel),
		.outSel(outSel), .outSoft(outSoft), .exposure_sync_out(exposure_sync_out), .pixel_reset_out(pixel_reset_out),
		.astableOut(astableOut), .acqTrigger(acqTrigger), .dlyPending(dlyPending), .evRunning(evRunning),
		.evFinal(evFinal), .isoOut(isoOut), .diffStatus(diffStatus));
	cctu_far_model far (.sys_clk(sys_clk), .exposure_sync_out(exposure_sync_out), .pixel_reset_out(pixel_reset_out),
		.isoIn(isoIn), .diffIn(diffIn), .lineIn(lineIn), .frameIn(frameIn), .expLen(expLen), .rstLen(rstLen));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// counts one-cycle trigger pulses and the gap between astable pulses
	always @(posedge sys_clk) begin
		if (acqTrigger === 1'b1) trigCnt <= trigCnt + 32'h1;
		astRun <= (astableOut === 1'b1) ? 32'h1 : astRun + 32'h1;
		if (astableOut === 1'b1) astGap <= astRun;
	end
	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic pulse(input int sel, input int k);
		repeat (k) begin
			far.sense(sel, 1'b1);
			step(5);
			far.sense(sel, 1'b0);
			step(5);
		end
	endtask : pulse
	initial begin
		{srst, acqActive, trigEdge, trigInvert, astEnable, dlyLines} = 6'h28;
		{trigSel, monoSrc, outSoft} = {3'h6, 2'h2, 2'h0};
		outSel[0] = CCTU_OS_SOFT;
		outSel[1] = CCTU_OS_SOFT;
		{astPeriod, exposeWidth, resetWidth, dlyCount} = {32'h0, 32'h3, 32'h5, 32'h0};
		evSel = CCTU_EV_LINE;
		gateSel = CCTU_GT_LINE;
		{trigCnt, astRun, astGap} = 96'h0;
		miscompares = 0;
		compares = 0;
		step(8);
		chk({exposure_sync_out, pixel_reset_out, acqTrigger, dlyPending, isoOut, evFinal[3:0]}, 32'h0);
		srst = 1'b0;
		// raw edge fires both pulses once, each with its own width
		trigSel = 3'h0;
		n0 = trigCnt;
		pulse(0, 1);
		step(80);
		chk(trigCnt - n0, 32'h1);
		chk(expLen >= 20 && expLen <= 40, 32'h1);
		chk(rstLen >= 40 && rstLen <= 60, 32'h1);
		$display("test mono done");
		// delay by time; a second edge while pending is dropped
		{monoSrc, exposeWidth, dlyCount, n0, n} = {2'h0, 32'h6, 32'h4, trigCnt, 32'h0};
		pulse(0, 2);
		step(120);
		chk(trigCnt - n0, 32'h1);
		chk(expLen >= 50 && expLen <= 70, 32'h1);
		far.sense(0, 1'b1);
		while (acqTrigger !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		if (n == 200) begin
			miscompares++;
			final_report();
		end
		chk(n >= 30 && n <= 60, 32'h1);
		far.sense(0, 1'b0);
		step(60);
		// delay by lines
		{dlyLines, dlyCount, n0} = {1'b1, 32'h2, trigCnt};
		pulse(0, 1);
		chk(dlyPending, 32'h1);
		pulse(6, 1);
		chk(trigCnt - n0, 32'h0);
		pulse(6, 1);
		step(5);
		chk(trigCnt - n0, 32'h1);
		$display("test delay done");
		// level hits from a differential pin, then inverted idle level
		{dlyLines, dlyCount, trigSel, trigEdge, n0} = {1'b0, 32'h0, 3'h3, 1'b0, trigCnt};
		far.sense(3, 1'b1);
		step(5);
		far.sense(3, 1'b0);
		step(10);
		chk(trigCnt - n0 >= 4 && trigCnt - n0 <= 6, 32'h1);
		{trigInvert, n0} = {1'b1, trigCnt};
		step(10);
		chk(trigCnt - n0 >= 8, 32'h1);
		{trigInvert, trigEdge, trigSel} = {1'b0, 1'b1, 3'h6};
		for (int i = 0; i < 4; i++) far.sense(2 + i, i[0]);
		step(5);
		chk(diffStatus, 32'ha);
		$display("test inputs done");
		// astable gap at a period of three ticks and at the minimum
		{astPeriod, astEnable} = {32'h3, 1'b1};
		step(80);
		chk(astGap, 32'd30);
		astPeriod = 32'h1;
		step(40);
		chk(astGap, 32'd10);
		astEnable = 1'b0;
		outSoft = 2'h2;
		step(3);
		chk(isoOut, 32'h2);
		outSoft = 2'h1;
		step(3);
		chk(isoOut, 32'h1);
		// exposure pulse routed to an output, fired by a line rise
		outSel[1] = CCTU_OS_EXPOSE;
		monoSrc = 2'h3;
		pulse(6, 1);
		chk(isoOut[1], 32'h1);
		$display("test astable done");
		// lines in a frame, then microseconds over the acquisition
		evSel = CCTU_EV_LINE;
		gateSel = CCTU_GT_FRAME;
		far.sense(7, 1'b1);
		step(10);
		pulse(6, 3);
		step(5);
		chk(evRunning, 32'h3);
		far.sense(7, 1'b0);
		step(10);
		chk(evFinal, 32'h3);
		evSel = CCTU_EV_USEC;
		gateSel = CCTU_GT_ACQ;
		acqActive = 1'b1;
		step(100);
		acqActive = 1'b0;
		step(5);
		chk(evFinal >= 9 && evFinal <= 11, 32'h1);
		$display("test events done");
		final_report();
	end
endmodule : tb
`default_nettype wire
